/* rtl/asac_pkg.sv */
// constants and types of the conversion abort and stop control
package asac_pkg;
    localparam logic [7:0] OFF_MODE_SELECT    = 8'h00;
    localparam logic [7:0] OFF_CHANNEL_SELECT = 8'h04;
    localparam logic [7:0] OFF_START_ADDRESS  = 8'h08;
    localparam logic [7:0] OFF_STATUS         = 8'h0c;
    localparam logic [7:0] OFF_IRQ_STATUS     = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK       = 8'h14;
    localparam logic [7:0] OFF_RESULT_BASE    = 8'h20;
    localparam int         NUM_CHANNELS       = 8;
    // start_address_reg fields
    localparam int BIT_CONVERT_ENABLE  = 4;
    localparam int BIT_SELECT_ADDR_EN  = 3;
    // status fields
    localparam int BIT_ST_CIP          = 0;
    localparam int BIT_ST_ALL_DONE     = 1;
    localparam int BIT_ST_OVERRUN      = 2;
    // irq status / mask fields
    localparam int BIT_IRQ_CONV_DONE   = 0;
    localparam int BIT_IRQ_SCAN_DONE   = 1;
    localparam int BIT_IRQ_OVERRUN     = 2;
    localparam int IRQ_BITS            = 3;
    // result word fields
    localparam int BIT_RES_VALID       = 10;
    localparam int BIT_RES_OVERRUN     = 11;
    // reset values
    localparam logic [1:0] RST_MODE_SELECT    = 2'h0;
    localparam logic [7:0] RST_CHANNEL_SELECT = 8'h00;
    localparam logic [2:0] RST_IRQ_MASK       = 3'h0;
    // mode encodings
    localparam logic [1:0] MODE_IDLE       = 2'h0;
    localparam logic [1:0] MODE_SINGLE     = 2'h1;
    localparam logic [1:0] MODE_SINGLE_SCAN = 2'h2;
    localparam logic [1:0] MODE_CONT_SCAN  = 2'h3;
    // timing
    localparam int CLK_PERIOD_NS       = 10;
    localparam int CONV_OSC_PERIOD_NS  = 80;
    localparam int CONV_OSC_CYCLES     = 14;
    localparam int SAMPLE_WINDOW_NS    = (3 * CONV_OSC_PERIOD_NS) / 2;
    localparam int SAMPLE_WINDOW_CYC   = SAMPLE_WINDOW_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } asac_state_t;

    typedef struct packed {
        logic       overrun;
        logic       valid;
        logic [9:0] data;
    } asac_result_t;
endpackage

/* rtl/asac_top.sv */
// conversion sequencer with abort, orderly stop and apb register file
//
// Behaviour
// - any write to mode_select_reg aborts the active conversion at once.
// - any write to channel_select_reg aborts the active conversion whatever the value.
// - a start_address_reg write with convert_enable or select_address_enable set aborts the active conversion.
// - a read of any result register aborts the active conversion.
// - writing zero to mode_select_reg acts as a full reset of the block.
// - each conversion takes its sample within the first one and a half oscillator cycles.
// - mode_select_reg resets to idle, and idle aborts conversions and releases the interrupt.
// - clearing convert_enable mid scan finishes the current channel and starts no other.
// - data_overrun_flag clears on a result read or a write to channel or mode select.
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ns
module asac_top #(
    parameter int CONV_CYCLES = asac_pkg::CONV_OSC_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        conv_osc,
    input  wire logic [9:0]  conv_data,
    output logic             sample_strobe,
    output logic             conv_in_progress,
    output logic             irq
);
    localparam int NC = asac_pkg::NUM_CHANNELS;

    asac_pkg::asac_state_t state, next_state;
    logic [1:0]            mode_select_reg, next_mode_select_reg;
    logic [NC-1:0]         channel_select_reg, next_channel_select_reg;
    logic                  convert_enable, next_convert_enable;
    logic [2:0]            channel_pointer, next_channel_pointer;
    logic [NC-1:0]         done_mask, next_done_mask;
    logic                  all_done, next_all_done;
    logic [4:0]            osc_cnt, next_osc_cnt;
    asac_pkg::asac_result_t result [NC], next_result [NC];
    logic [2:0]            irq_status, next_irq_status;
    logic [2:0]            irq_mask, next_irq_mask;
    logic [31:0]           next_prdata;
    logic                  next_pready, next_pslverr, next_sample_strobe, next_irq;
    logic                  osc_s1, osc_s2, osc_s3;
    logic                  osc_rise;
    logic                  acc, wr, rd, hit_res, wr_msr, wr_csr, wr_sar, rd_res, abort, start;
    logic [2:0]            res_idx;

    assign osc_rise = osc_s2 & ~osc_s3;
    assign acc      = psel & penable & pready;
    assign wr       = acc & pwrite;
    assign rd       = acc & ~pwrite;
    assign hit_res  = (paddr >= asac_pkg::OFF_RESULT_BASE) && (paddr[1:0] == 2'h0)
                      && (paddr < asac_pkg::OFF_RESULT_BASE + 8'(4 * NC));
    assign res_idx  = 3'((paddr - asac_pkg::OFF_RESULT_BASE) >> 2);
    assign wr_msr   = wr && paddr == asac_pkg::OFF_MODE_SELECT;
    assign wr_csr   = wr && paddr == asac_pkg::OFF_CHANNEL_SELECT;
    assign wr_sar   = wr && paddr == asac_pkg::OFF_START_ADDRESS;
    assign rd_res   = rd && hit_res;
    assign abort    = wr_msr | wr_csr | rd_res
                      | (wr_sar & (pwdata[asac_pkg::BIT_CONVERT_ENABLE] | pwdata[asac_pkg::BIT_SELECT_ADDR_EN]));
    assign start    = wr_sar & pwdata[asac_pkg::BIT_CONVERT_ENABLE] & (mode_select_reg != asac_pkg::MODE_IDLE);

    // next selected channel after ch, wrapping; ch itself when nothing else is selected
    function automatic logic [2:0] next_active(input logic [2:0] ch, input logic [NC-1:0] sel);
        logic [2:0] r;
        logic       found;
        r = ch;
        found = 1'b0;
        for (int i = 1; i <= NC; i++) begin
            if (!found && sel[3'(ch + 3'(i))]) begin
                r = 3'(ch + 3'(i));
                found = 1'b1;
            end
        end
        return r;
    endfunction

    always_comb begin
        logic [NC-1:0] dm;
        dm = done_mask | (NC'(1) << channel_pointer);
        next_state              = state;
        next_mode_select_reg    = mode_select_reg;
        next_channel_select_reg = channel_select_reg;
        next_convert_enable     = convert_enable;
        next_channel_pointer    = channel_pointer;
        next_done_mask          = done_mask;
        next_all_done           = all_done;
        next_osc_cnt            = osc_cnt;
        next_result             = result;
        next_irq_status         = irq_status;
        next_irq_mask           = irq_mask;
        next_sample_strobe      = 1'b0;
        // conversion timing on the sampled oscillator
        if (state == asac_pkg::ST_CONV && osc_rise) begin
            next_osc_cnt = 5'(osc_cnt + 5'h1);
            if (osc_cnt == 5'h0) begin
                next_sample_strobe = 1'b1;
            end
            if (osc_cnt == 5'(CONV_CYCLES - 1)) begin
                next_osc_cnt = 5'h0;
                next_result[channel_pointer].data  = conv_data;
                next_result[channel_pointer].valid = 1'b1;
                next_irq_status[asac_pkg::BIT_IRQ_CONV_DONE] = 1'b1;
                if (result[channel_pointer].valid) begin
                    next_result[channel_pointer].overrun = 1'b1;
                    next_irq_status[asac_pkg::BIT_IRQ_OVERRUN] = 1'b1;
                end
                next_done_mask = dm;
                if ((dm & channel_select_reg) == channel_select_reg) begin
                    next_all_done = 1'b1;
                    next_irq_status[asac_pkg::BIT_IRQ_SCAN_DONE] = 1'b1;
                    if (mode_select_reg == asac_pkg::MODE_CONT_SCAN) begin
                        next_done_mask = '0;
                    end
                end
                if (!convert_enable || mode_select_reg == asac_pkg::MODE_SINGLE
                    || (mode_select_reg == asac_pkg::MODE_SINGLE_SCAN
                        && (dm & channel_select_reg) == channel_select_reg)) begin
                    next_state = asac_pkg::ST_IDLE;
                    next_convert_enable = 1'b0;
                end else begin
                    next_channel_pointer = next_active(channel_pointer, channel_select_reg);
                end
            end
        end
        // software writes and reads
        if (abort) begin
            next_state    = asac_pkg::ST_IDLE;
            next_osc_cnt  = 5'h0;
            next_convert_enable = 1'b0;
            for (int i = 0; i < NC; i++) begin
                next_result[i].valid = 1'b0;
            end
        end
        if (wr_msr) begin
            next_mode_select_reg = pwdata[1:0];
            for (int i = 0; i < NC; i++) begin
                next_result[i].overrun = 1'b0;
            end
            if (pwdata[1:0] == asac_pkg::MODE_IDLE) begin
                next_channel_select_reg = asac_pkg::RST_CHANNEL_SELECT;
                next_channel_pointer = 3'h0;
                next_done_mask = '0;
                next_all_done = 1'b0;
                next_irq_status = '0;
                next_irq_mask = asac_pkg::RST_IRQ_MASK;
                for (int i = 0; i < NC; i++) begin
                    next_result[i] = '0;
                end
            end
        end
        if (wr_csr) begin
            next_channel_select_reg = pwdata[NC-1:0];
            next_done_mask = '0;
            for (int i = 0; i < NC; i++) begin
                next_result[i].overrun = 1'b0;
            end
        end
        if (rd_res) begin
            next_result[res_idx].overrun = 1'b0;
        end
        if (wr_sar) begin
            if (pwdata[asac_pkg::BIT_SELECT_ADDR_EN]) begin
                next_channel_pointer = pwdata[2:0];
            end
            if (start) begin
                next_state = asac_pkg::ST_CONV;
                next_convert_enable = 1'b1;
                next_all_done = 1'b0;
            end else if (!pwdata[asac_pkg::BIT_CONVERT_ENABLE]) begin
                next_convert_enable = 1'b0;
            end
        end
        if (wr && paddr == asac_pkg::OFF_IRQ_MASK) begin
            next_irq_mask = pwdata[2:0];
        end
        // write one to clear; a new event in the same cycle wins only on a bit that was clear before
        if (wr && paddr == asac_pkg::OFF_IRQ_STATUS) begin
            next_irq_status = next_irq_status & ~(pwdata[2:0] & ~(next_irq_status & ~irq_status));
        end
        next_irq = (mode_select_reg != asac_pkg::MODE_IDLE) && |(irq_status & irq_mask);
    end

    // apb answer, one wait state
    always_comb begin
        next_pready  = psel & penable & ~pready;
        next_prdata  = 32'h0;
        next_pslverr = 1'b0;
        if (psel && penable && !pready) begin
            if (hit_res) begin
                next_prdata = 32'(result[res_idx]);
            end else begin
                case (paddr)
                    asac_pkg::OFF_MODE_SELECT:    next_prdata = 32'(mode_select_reg);
                    asac_pkg::OFF_CHANNEL_SELECT: next_prdata = 32'(channel_select_reg);
                    asac_pkg::OFF_START_ADDRESS:  next_prdata = 32'({convert_enable, 1'b0, channel_pointer});
                    asac_pkg::OFF_STATUS: begin
                        next_prdata[asac_pkg::BIT_ST_CIP]      = (state == asac_pkg::ST_CONV);
                        next_prdata[asac_pkg::BIT_ST_ALL_DONE] = all_done;
                        for (int i = 0; i < NC; i++) begin
                            next_prdata[asac_pkg::BIT_ST_OVERRUN] = next_prdata[asac_pkg::BIT_ST_OVERRUN]
                                                                    | result[i].overrun;
                        end
                    end
                    asac_pkg::OFF_IRQ_STATUS:     next_prdata = 32'(irq_status);
                    asac_pkg::OFF_IRQ_MASK:       next_prdata = 32'(irq_mask);
                    default:                      next_pslverr = 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state              <= asac_pkg::ST_IDLE;
            mode_select_reg    <= asac_pkg::RST_MODE_SELECT;
            channel_select_reg <= asac_pkg::RST_CHANNEL_SELECT;
            convert_enable     <= 1'b0;
            channel_pointer    <= 3'h0;
            done_mask          <= '0;
            all_done           <= 1'b0;
            osc_cnt            <= 5'h0;
            for (int i = 0; i < NC; i++) begin
                result[i] <= '0;
            end
            irq_status         <= '0;
            irq_mask           <= asac_pkg::RST_IRQ_MASK;
            prdata             <= 32'h0;
            pready             <= 1'b0;
            pslverr            <= 1'b0;
            sample_strobe      <= 1'b0;
            conv_in_progress   <= 1'b0;
            irq                <= 1'b0;
            osc_s1             <= 1'b0;
            osc_s2             <= 1'b0;
            osc_s3             <= 1'b0;
        end else begin
            state              <= next_state;
            mode_select_reg    <= next_mode_select_reg;
            channel_select_reg <= next_channel_select_reg;
            convert_enable     <= next_convert_enable;
            channel_pointer    <= next_channel_pointer;
            done_mask          <= next_done_mask;
            all_done           <= next_all_done;
            osc_cnt            <= next_osc_cnt;
            result             <= next_result;
            irq_status         <= next_irq_status;
            irq_mask           <= next_irq_mask;
            prdata             <= next_prdata;
            pready             <= next_pready;
            pslverr            <= next_pslverr;
            sample_strobe      <= next_sample_strobe;
            conv_in_progress   <= (next_state == asac_pkg::ST_CONV);
            irq                <= next_irq;
            osc_s1             <= conv_osc;
            osc_s2             <= osc_s1;
            osc_s3             <= osc_s2;
        end
    end

    chk_msr_abort: assert property (@(posedge pclk) disable iff (!presetn)
        wr_msr |=> state == asac_pkg::ST_IDLE && !convert_enable) else $error("mode write did not abort");
    chk_csr_abort: assert property (@(posedge pclk) disable iff (!presetn)
        wr_csr |=> state == asac_pkg::ST_IDLE ##1 !conv_in_progress) else $error("channel write did not abort");
    chk_sar_abort: assert property (@(posedge pclk) disable iff (!presetn)
        wr_sar && pwdata[asac_pkg::BIT_SELECT_ADDR_EN] && !pwdata[asac_pkg::BIT_CONVERT_ENABLE]
        |=> state == asac_pkg::ST_IDLE && result[0].valid == 1'b0) else $error("address write did not abort");
    chk_read_abort: assert property (@(posedge pclk) disable iff (!presetn)
        rd_res |=> state == asac_pkg::ST_IDLE && result[$past(res_idx)].overrun == 1'b0)
        else $error("result read did not abort");
    chk_zero_reset: assert property (@(posedge pclk) disable iff (!presetn)
        wr_msr && pwdata[1:0] == 2'h0 |=> channel_select_reg == 8'h00 && irq_status == 3'h0 ##1 !irq)
        else $error("zero mode write not a reset");
    chk_sample_win: assert property (@(posedge pclk) disable iff (!presetn)
        state == asac_pkg::ST_CONV && osc_rise && osc_cnt == 5'h0 && !abort |=> sample_strobe)
        else $error("sample not taken at first oscillator edge");
    chk_idle_irq: assert property (@(posedge pclk) disable iff (!presetn)
        mode_select_reg == asac_pkg::MODE_IDLE |=> !irq) else $error("interrupt active in idle");
    chk_stop_end: assert property (@(posedge pclk) disable iff (!presetn)
        state == asac_pkg::ST_CONV && !convert_enable && osc_rise && osc_cnt == 5'(CONV_CYCLES - 1)
        && !wr_sar && !wr_msr
        |=> state == asac_pkg::ST_IDLE && $stable(channel_pointer)) else $error("scan went on after stop");
    chk_no_resume: assert property (@(posedge pclk) disable iff (!presetn)
        state == asac_pkg::ST_IDLE && !start |=> state == asac_pkg::ST_IDLE) else $error("sequencer resumed");
endmodule

/* test/asac_osc_model.sv */
// conversion oscillator and converter data source seen at the far side of the sequencer
`timescale 1ns/1ns
module asac_osc_model (
    input  wire logic       pclk,
    input  wire logic       run,
    output logic            conv_osc,
    output logic [9:0]      conv_data
);
    // oscillator only runs while a conversion is active, parked low otherwise
    initial begin
        conv_osc = 1'b0;
        forever begin
            #40;
            if (run) begin
                conv_osc = ~conv_osc;
            end else begin
                conv_osc = 1'b0;
            end
        end
    end

    // data holds during a conversion and toggles every cycle outside, so stale values never look valid
    initial begin
        conv_data = 10'h155;
        forever begin
            @(posedge pclk);
            if (!run) begin
                conv_data <= ~conv_data;
            end
        end
    end
endmodule

/* test/tb.sv */
// self-checking bench for the conversion abort and stop control
`timescale 1ns/1ns
module tb;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        conv_osc;
    logic [9:0]  conv_data;
    logic        sample_strobe;
    logic        conv_in_progress;
    logic        irq;
    logic [31:0] r;
    logic        e;
    logic [31:0] hi;
    logic [7:0]  rnd;
    logic [9:0]  dsave;
    int          num_errors;
    int          checks;
    int          n;

    asac_top #(.CONV_CYCLES(3)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .conv_osc(conv_osc), .conv_data(conv_data), .sample_strobe(sample_strobe),
        .conv_in_progress(conv_in_progress), .irq(irq));
    asac_osc_model i_osc (.pclk(pclk), .run(conv_in_progress), .conv_osc(conv_osc), .conv_data(conv_data));

    always #5 pclk = ~pclk;

    task automatic close_out;
        if (num_errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            num_errors++;
            close_out();
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic wait_cip(input logic v);
        n = 0;
        while (conv_in_progress !== v && n < 400) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 400) begin
            num_errors++;
            close_out();
        end
    endtask

    // counts cycles in which a conversion is active
    task automatic quiet(input int c);
        hi = 32'h0;
        repeat (c) begin
            @(posedge pclk);
            if (conv_in_progress !== 1'b0) hi++;
        end
    endtask

    task automatic wait_strobe;
        n = 0;
        while (sample_strobe !== 1'b1 && n < 40) begin
            @(posedge pclk);
            n++;
        end
    endtask

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        num_errors = 0;
        checks = 0;
        rnd = 8'($urandom(71456));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(asac_pkg::OFF_MODE_SELECT);
        chk(r, 32'h0);
        rd(asac_pkg::OFF_CHANNEL_SELECT);
        chk(r, 32'h0);
        rd(8'h40);
        chk({31'h0, e}, 32'h1);
        wr(asac_pkg::OFF_START_ADDRESS, 32'h10);
        quiet(30);
        chk(hi, 32'h0);
        // single conversion with interrupt raise, mask and clear
        wr(asac_pkg::OFF_MODE_SELECT, 32'(asac_pkg::MODE_SINGLE));
        wr(asac_pkg::OFF_IRQ_MASK, 32'h1);
        rnd = 8'($urandom);
        // convert_enable and select_address_enable together: point at the random channel, then start
        wr(asac_pkg::OFF_START_ADDRESS, {28'h1, 1'b1, rnd[2:0]});
        wait_strobe();
        chk(32'(n <= asac_pkg::SAMPLE_WINDOW_CYC), 32'h1);
        // far side holds its data while a conversion runs
        dsave = conv_data;
        wait_cip(1'b0);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        wr(asac_pkg::OFF_IRQ_MASK, 32'h0);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        wr(asac_pkg::OFF_IRQ_STATUS, 32'h1);
        rd(asac_pkg::OFF_IRQ_STATUS);
        chk({31'h0, r[0]}, 32'h0);
        rd(asac_pkg::OFF_RESULT_BASE + {3'h0, rnd[2:0], 2'b00});
        chk({31'h0, r[asac_pkg::BIT_RES_VALID]}, 32'h1);
        chk({22'h0, r[9:0]}, {22'h0, dsave});
        rd(asac_pkg::OFF_RESULT_BASE + {3'h0, rnd[2:0], 2'b00});
        chk({31'h0, r[asac_pkg::BIT_RES_VALID]}, 32'h0);
        quiet(40);
        chk(hi, 32'h0);
        // each abort kind during a continuous scan
        wr(asac_pkg::OFF_MODE_SELECT, 32'(asac_pkg::MODE_CONT_SCAN));
        wr(asac_pkg::OFF_CHANNEL_SELECT, 32'hff);
        for (int k = 0; k < 4; k++) begin
            wr(asac_pkg::OFF_START_ADDRESS, 32'h10);
            wait_cip(1'b1);
            rnd = 8'($urandom);
            case (k)
                0: wr(asac_pkg::OFF_MODE_SELECT, 32'(asac_pkg::MODE_CONT_SCAN));
                1: wr(asac_pkg::OFF_CHANNEL_SELECT, {24'h0, rnd | 8'h01});
                2: wr(asac_pkg::OFF_START_ADDRESS, {28'h0, 1'b1, rnd[2:0]});
                default: rd(asac_pkg::OFF_RESULT_BASE + {3'h0, rnd[2:0], 2'b00});
            endcase
            quiet(40);
            chk(hi, 32'h0);
        end
        // orderly stop of a single scan
        wr(asac_pkg::OFF_MODE_SELECT, 32'(asac_pkg::MODE_SINGLE_SCAN));
        wr(asac_pkg::OFF_CHANNEL_SELECT, 32'hff);
        wr(asac_pkg::OFF_IRQ_STATUS, 32'h7);
        wr(asac_pkg::OFF_START_ADDRESS, 32'h10);
        wait_strobe();
        wr(asac_pkg::OFF_START_ADDRESS, 32'h0);
        wait_cip(1'b0);
        quiet(60);
        chk(hi, 32'h0);
        rd(asac_pkg::OFF_IRQ_STATUS);
        chk({30'h0, r[1:0]}, 32'h1);
        // complete single scan over channels 1 and 2, started at channel 1
        wr(asac_pkg::OFF_CHANNEL_SELECT, 32'h06);
        wr(asac_pkg::OFF_IRQ_STATUS, 32'h7);
        wr(asac_pkg::OFF_START_ADDRESS, 32'h19);
        wait_cip(1'b0);
        quiet(30);
        chk(hi, 32'h0);
        rd(asac_pkg::OFF_IRQ_STATUS);
        chk({30'h0, r[1:0]}, 32'h3);
        rd(asac_pkg::OFF_STATUS);
        chk({30'h0, r[1:0]}, 32'h2);
        // overrun flag set by repeated conversion, cleared by a channel write
        wr(asac_pkg::OFF_MODE_SELECT, 32'(asac_pkg::MODE_CONT_SCAN));
        wr(asac_pkg::OFF_CHANNEL_SELECT, 32'h01);
        wr(asac_pkg::OFF_START_ADDRESS, 32'h10);
        for (int i = 0; i < 60; i++) begin
            rd(asac_pkg::OFF_STATUS);
            if (r[asac_pkg::BIT_ST_OVERRUN] === 1'b1) break;
        end
        chk({31'h0, r[asac_pkg::BIT_ST_OVERRUN]}, 32'h1);
        wr(asac_pkg::OFF_CHANNEL_SELECT, 32'h01);
        rd(asac_pkg::OFF_STATUS);
        chk({31'h0, r[asac_pkg::BIT_ST_OVERRUN]}, 32'h0);
        // zero mode write behaves as a reset
        wr(asac_pkg::OFF_CHANNEL_SELECT, 32'h5a);
        wr(asac_pkg::OFF_IRQ_MASK, 32'h7);
        wr(asac_pkg::OFF_MODE_SELECT, 32'(asac_pkg::MODE_SINGLE));
        wr(asac_pkg::OFF_START_ADDRESS, 32'h10);
        wait_cip(1'b1);
        wr(asac_pkg::OFF_MODE_SELECT, 32'h0);
        // irq is registered from the mode one cycle late; let it settle
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        rd(asac_pkg::OFF_CHANNEL_SELECT);
        chk(r, 32'h0);
        rd(asac_pkg::OFF_IRQ_MASK);
        chk(r, 32'h0);
        quiet(30);
        chk(hi, 32'h0);
        close_out();
    end
endmodule
